// ===== hdl/compare_capture_timer.sv
`timescale 1ns/10ps
`include "cct_map.svh"

// How it works
// RULE1: Narrow variant counter is sixteen bits, counting clocks or external ticks.
// RULE2: Wide variant is identical except its counter is thirty-two bits.
// RULE3: Up to four channels, each capture, compare or pwm mode.
// RULE4: Capture copies the counter into the channel buffer on input edge.
// RULE5: Compare output shows counter versus programmed threshold.
// RULE6: Pwm output follows successive compare values, reloaded at each wrap.
// RULE7: Dead-time insertion exists only in the first unit of each variant.
// RULE8: Overflow and match events go out to the event routing network.
// RULE9: Counter steps by one per tick and wraps to zero after all ones.

module compare_capture_timer #(
	parameter int WIDTH             = `CCT_NARROW_WIDTH,
	parameter int CHANNELS          = `CCT_CHANNELS,
	parameter int DEAD_WIDTH        = `CCT_DEAD_WIDTH,
	parameter bit DEAD_TIME_PRESENT = 1'b1
) (
	input  wire logic                      clock,
	input  wire logic                      rst,
	input  wire logic                      run,
	input  wire logic                      tick_select,
	input  wire logic                      tick_pin,
	input  wire logic [2*CHANNELS-1:0]     mode_code,
	input  wire logic [CHANNELS-1:0]       cmp_write,
	input  wire logic [WIDTH*CHANNELS-1:0] cmp_data,
	input  wire logic [CHANNELS-1:0]       capture_pin,
	input  wire logic                      dead_enable,
	input  wire logic [DEAD_WIDTH-1:0]     dead_time,
	output logic [WIDTH-1:0]               count,
	output logic [CHANNELS-1:0]            chan_out,
	output logic [CHANNELS-1:0]            chan_out_n,
	output logic [WIDTH*CHANNELS-1:0]      capture_value,
	output logic [CHANNELS-1:0]            capture_event,
	output logic [CHANNELS-1:0]            match_event,
	output logic                           overflow_event
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [CHANNELS:0] sync_meta;
	logic [CHANNELS:0] sync_hold;
	logic [CHANNELS:0] sync_last;
	logic [CHANNELS:0] pin_edge;

	// Two stages before use; a third stage only for the edge detect.
	// Limitation: a pin must stay high and low for more than one clock,
	// and its edge reaches the counter or a capture two to three clocks late.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sync_meta <= '0;
			sync_hold <= '0;
			sync_last <= '0;
		end else begin
			sync_meta <= {tick_pin, capture_pin};
			sync_hold <= sync_meta;
			sync_last <= sync_hold;
		end
	end

	assign pin_edge = sync_hold & ~sync_last;

	// ----------------------------------------
	// Core counter
	// ----------------------------------------
	logic             tick;
	logic             wrap;
	logic [WIDTH-1:0] next_count;
	logic             next_overflow;

	// Width set by WIDTH: 16 for the narrow unit, 32 for wide_timer
	always_comb begin
		tick          = run && (tick_select ? pin_edge[CHANNELS] : 1'h1);
		wrap          = tick && (count == '1); // RULE9
		next_count    = count;
		next_overflow = wrap; // RULE8
		if (tick) begin
			next_count = WIDTH'(count + 1'h1); // RULE1 RULE2 RULE9
		end
	end

	// Register stage
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			count          <= {WIDTH{`CCT_COUNT_RESET}};
			overflow_event <= 1'h0;
		end else begin
			count          <= next_count;
			overflow_event <= next_overflow;
		end
	end

	// ----------------------------------------
	// Channels and output stage
	// ----------------------------------------
	logic [CHANNELS-1:0] raw_out;

	genvar i;
	generate
		for (i = 0; i < CHANNELS; i++) begin : g_chan
			logic [DEAD_WIDTH-1:0] gap;
			logic                  level;
			logic [DEAD_WIDTH-1:0] next_gap;
			logic                  next_level;
			logic                  next_out;
			logic                  next_out_n;

			// Each channel picks its own mode
			cct_channel #(
				.WIDTH (WIDTH)
			) u_chan (
				.clock      (clock),
				.rst        (rst),
				.count      (count),
				.tick       (tick),
				.wrap       (wrap),
				.mode_code  (mode_code[2*i +: 2]),
				.cmp_write  (cmp_write[i]),
				.cmp_data   (cmp_data[WIDTH*i +: WIDTH]),
				.cap_edge   (pin_edge[i]),
				.raw_out    (raw_out[i]),
				.match      (match_event[i]),
				.cap_strobe (capture_event[i]),
				.cap_value  (capture_value[WIDTH*i +: WIDTH])
			); // RULE3 RULE8

			// Dead time: on each edge of the raw level both legs sit low
			// for dead_time cycles, so complementary drivers never overlap.
			// The gap delays the output; pulses shorter than it are lost.
			always_comb begin
				next_gap   = gap;
				next_level = level;
				next_out   = raw_out[i];
				next_out_n = ~raw_out[i];
				if (DEAD_TIME_PRESENT && dead_enable) begin // RULE7
					if (raw_out[i] != level) begin
						next_level = raw_out[i];
						next_gap   = dead_time;
					end else if (gap != '0) begin
						next_gap = DEAD_WIDTH'(gap - 1'h1);
					end
					next_out   = (next_gap == '0) && next_level;
					next_out_n = (next_gap == '0) && !next_level;
				end else begin
					next_level = raw_out[i];
					next_gap   = '0;
				end
			end

			// Register stage
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					gap           <= `CCT_DEAD_RESET;
					level         <= `CCT_OUT_RESET;
					chan_out[i]   <= `CCT_OUT_RESET;
					chan_out_n[i] <= `CCT_OUT_RESET;
				end else begin
					gap           <= next_gap;
					level         <= next_level;
					chan_out[i]   <= next_out;
					chan_out_n[i] <= next_out_n;
				end
			end

			chk_no_overlap: assert property (@(posedge clock) disable iff (rst) // RULE7
				!(chan_out[i] && chan_out_n[i]))
				else $error("complementary outputs overlap");
			chk_plain_complement: assert property (@(posedge clock) disable iff (rst) // RULE7
				!(DEAD_TIME_PRESENT && dead_enable) && !$past(rst)
				|=> chan_out_n[i] == !chan_out[i])
				else $error("outputs not complementary without dead time");
			chk_dead_gap: assert property (@(posedge clock) disable iff (rst) // RULE7
				DEAD_TIME_PRESENT && dead_enable && $past(dead_enable) && dead_time != '0
				&& raw_out[i] != level |=> !chan_out[i] && !chan_out_n[i])
				else $error("dead time gap missing");
			// An illegal mode code keeps the channel silent: no level, no events
			chk_illegal_quiet: assert property (@(posedge clock) disable iff (rst) // RULE3
				mode_code[2*i +: 2] == 2'h3
				|=> !raw_out[i] && !match_event[i] && !capture_event[i])
				else $error("illegal mode channel not quiet");
			chk_capture_mode: assert property (@(posedge clock) disable iff (rst) // RULE4
				capture_event[i] |-> $past(mode_code[2*i +: 2]) == 2'h0)
				else $error("capture event outside capture mode");
			cov_dead_gap: cover property (@(posedge clock) disable iff (rst)
				gap != '0 ##1 gap == '0);
		end
	endgenerate

	// ----------------------------------------
	// Counter checks
	// ----------------------------------------
	chk_count_step: assert property (@(posedge clock) disable iff (rst) // RULE1
		tick |=> count == WIDTH'($past(count) + 1'h1))
		else $error("counter did not step");
	chk_count_wrap: assert property (@(posedge clock) disable iff (rst) // RULE9
		wrap |=> count == '0 && overflow_event)
		else $error("counter did not wrap");
	chk_count_hold: assert property (@(posedge clock) disable iff (rst) // RULE2
		!tick |=> $stable(count))
		else $error("counter moved without tick");
	chk_overflow_only: assert property (@(posedge clock) disable iff (rst) // RULE8
		overflow_event |-> $past(count) == '1 && count == '0)
		else $error("overflow event without wrap");
	chk_ext_tick: assert property (@(posedge clock) disable iff (rst) // RULE1
		run && tick_select && !sync_hold[CHANNELS] |=> $stable(count))
		else $error("external tick counted without edge");
	chk_overflow_pulse: assert property (@(posedge clock) disable iff (rst) // RULE8
		overflow_event |=> !overflow_event)
		else $error("overflow event longer than one cycle");
	// One pin edge must count once, however long the pin stays high
	chk_edge_once: assert property (@(posedge clock) disable iff (rst) // RULE1
		pin_edge[CHANNELS] |=> !pin_edge[CHANNELS])
		else $error("tick edge seen twice");

	cov_wrap: cover property (@(posedge clock) disable iff (rst) overflow_event);
	cov_capture: cover property (@(posedge clock) disable iff (rst) |capture_event);
	cov_match: cover property (@(posedge clock) disable iff (rst) |match_event);
	// Counting on the pin rather than on the clock
	cov_ext_count: cover property (@(posedge clock) disable iff (rst) run && tick_select && tick);

endmodule : compare_capture_timer

// ===== hdl/cct_map.svh
`ifndef CCT_MAP_SVH
`define CCT_MAP_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define CCT_NARROW_WIDTH 16
`define CCT_WIDE_WIDTH   32
`define CCT_CHANNELS     4
`define CCT_DEAD_WIDTH   8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CCT_COUNT_RESET  1'h0
`define CCT_OUT_RESET    1'h0
`define CCT_DEAD_RESET   8'h00

`endif

// ===== hdl/cct_pkg.sv
package cct_pkg;

	// ----------------------------------------
	// Channel modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		capture_mode,
		compare_mode,
		pwm_mode
	} mode_t;

endpackage : cct_pkg

// ===== hdl/cct_channel.sv
`timescale 1ns/10ps
`include "cct_map.svh"

module cct_channel #(
	parameter int WIDTH = `CCT_NARROW_WIDTH
) (
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] count,
	input  wire logic             tick,
	input  wire logic             wrap,
	input  wire logic [1:0]       mode_code,
	input  wire logic             cmp_write,
	input  wire logic [WIDTH-1:0] cmp_data,
	input  wire logic             cap_edge,
	output logic                  raw_out,
	output logic                  match,
	output logic                  cap_strobe,
	output logic [WIDTH-1:0]      cap_value
);

	cct_pkg::mode_t   mode;
	logic [WIDTH-1:0] buffer;
	logic [WIDTH-1:0] active;
	logic [WIDTH-1:0] next_buffer;
	logic [WIDTH-1:0] next_active;
	logic [WIDTH-1:0] next_cap_value;
	logic             next_raw_out;
	logic             next_match;
	logic             next_cap_strobe;

	// ----------------------------------------
	// Per-mode next state
	// ----------------------------------------
	// Code 3 is illegal and parks the output low
	always_comb begin
		mode            = cct_pkg::mode_t'(mode_code);
		next_buffer     = cmp_write ? cmp_data : buffer;
		next_active     = active;
		next_cap_value  = cap_value;
		next_cap_strobe = 1'h0;
		next_match      = 1'h0;
		next_raw_out    = 1'h0;
		unique case (mode)
			cct_pkg::capture_mode: begin
				if (cap_edge) begin
					next_cap_value  = count; // RULE4
					next_cap_strobe = 1'h1;
				end
			end
			cct_pkg::compare_mode: begin
				next_active  = next_buffer;
				next_raw_out = (count >= active); // RULE5
				next_match   = tick && (count == active); // RULE8
			end
			cct_pkg::pwm_mode: begin
				// Reload only at wrap so a period never sees a torn threshold
				if (wrap) begin
					next_active = next_buffer; // RULE6
				end
				next_raw_out = (count < active); // RULE6
				next_match   = tick && (count == active); // RULE8
			end
			default: begin
				next_raw_out = 1'h0;
			end
		endcase
	end

	// Register stage
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			buffer     <= '0;
			active     <= '0;
			cap_value  <= '0;
			cap_strobe <= 1'h0;
			match      <= 1'h0;
			raw_out    <= `CCT_OUT_RESET;
		end else begin
			buffer     <= next_buffer;
			active     <= next_active;
			cap_value  <= next_cap_value;
			cap_strobe <= next_cap_strobe;
			match      <= next_match;
			raw_out    <= next_raw_out;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_capture_copy: assert property (@(posedge clock) disable iff (rst) // RULE4
		cap_edge && mode == cct_pkg::capture_mode |=> cap_strobe && cap_value == $past(count))
		else $error("capture did not copy the counter");
	chk_compare_level: assert property (@(posedge clock) disable iff (rst) // RULE5
		mode == cct_pkg::compare_mode ##1 mode == cct_pkg::compare_mode
		|=> raw_out == ($past(count) >= $past(active)))
		else $error("compare output does not follow threshold");
	chk_pwm_reload: assert property (@(posedge clock) disable iff (rst) // RULE6
		wrap && mode == cct_pkg::pwm_mode && !cmp_write |=> active == $past(buffer))
		else $error("pwm threshold not reloaded at wrap");
	chk_match_event: assert property (@(posedge clock) disable iff (rst) // RULE8
		tick && count == active
		&& (mode == cct_pkg::compare_mode || mode == cct_pkg::pwm_mode) |=> match)
		else $error("match event missing");

endmodule : cct_channel

// ===== verif/compare_capture_timer_tb_top.sv
`timescale 1ns/10ps

module compare_capture_timer_tb_top;
	// ----------------------------------------
	// Stimulus, outputs and model state
	// ----------------------------------------
	logic        clock = 1'h0, rst = 1'h1, run = 1'h0, track = 1'h1;
	logic        tick_select = 1'h0, tick_pin = 1'h0, dead_enable = 1'h0;
	logic [7:0]  mode_code = 8'he4, dead_time = 8'h00;
	logic [3:0]  cmp_write = 4'h0, capture_pin = 4'h0;
	logic [63:0] cmp_data = '0, capture_value;
	logic [15:0] count, t1, t2, m_count = 16'h0000;
	logic [3:0]  chan_out, chan_out_n, capture_event, match_event;
	logic        overflow_event;
	logic [31:0] lfsr = 32'h2736;
	logic [7:0]  dts [2] = '{8'h00, 8'h03};
	int          n_mismatch = 0, compares = 0, cycles = 0;
	int          n_ovf = 0, n_match = 0, ext, gap, k;
	int          n_match2 = 0, n_quiet = 0;

	// Free running clock
	initial begin
		forever #5 clock = ~clock;
	end

	compare_capture_timer #(.WIDTH(16), .DEAD_TIME_PRESENT(1'b1)) dut (
		.clock(clock), .rst(rst), .run(run), .tick_select(tick_select),
		.tick_pin(tick_pin), .mode_code(mode_code), .cmp_write(cmp_write),
		.cmp_data(cmp_data), .capture_pin(capture_pin), .dead_enable(dead_enable),
		.dead_time(dead_time), .count(count), .chan_out(chan_out),
		.chan_out_n(chan_out_n), .capture_value(capture_value),
		.capture_event(capture_event), .match_event(match_event),
		.overflow_event(overflow_event));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check_word

	task automatic check_bit(input string what, input logic exp, input logic got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check_bit

	task automatic give_verdict();
		$display("Mismatches %0d, compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : give_verdict

	function automatic logic [31:0] next_rand();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction : next_rand

	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask : cyc

	// One-cycle threshold strobe for channel i
	task automatic wr(input int i, input logic [15:0] v);
		cmp_data[16*i+:16] = v;
		cmp_write[i] = 1'h1;
		cyc(1);
		cmp_write[i] = 1'h0;
		cyc(1);
	endtask : wr

	// Pin edge with the counter stopped, so the captured value is known
	task automatic pin(input int i, input logic hit);
		int ev = 0;
		capture_pin[i] = 1'h1;
		repeat (8) begin
			@(negedge clock);
			ev += (capture_event[i] === 1'h1);
		end
		capture_pin[i] = 1'h0;
		cyc(4);
		check_word("capture events", {31'h0, hit}, ev);
		if (hit) check_word("capture value", m_count, capture_value[16*i+:16]);
	endtask : pin

	// ----------------------------------------
	// Reference counter, tallies and timeout
	// ----------------------------------------
	always @(posedge clock) begin
		if (rst) m_count <= 16'h0000;
		else if (run && !tick_select) m_count <= m_count + 16'h0001;
	end

	// Sampled mid-cycle so one-cycle pulses are seen exactly once
	always @(negedge clock) begin
		if (!rst) begin
			cycles++;
			n_ovf += (overflow_event === 1'h1);
			n_match += (match_event[1] === 1'h1);
			n_match2 += (match_event[2] === 1'h1);
			n_quiet += (match_event[3] === 1'h1 || capture_event[3] === 1'h1 || chan_out[3] === 1'h1);
			if (track) check_word("count", m_count, count);
			if (cycles > 90000) begin
				n_mismatch++;
				give_verdict();
			end
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		cyc(6);
		check_word("outputs in reset", 0, {chan_out, chan_out_n, capture_event});
		rst = 1'h0;
		t1 = next_rand();
		t2 = next_rand();
		ext = next_rand() % 2000 + 1;
		wr(1, t1);
		wr(2, t2);
		// One full period plus a random tail; pwm takes its threshold at the wrap
		run = 1'h1;
		cyc(65536 + ext);
		run = 1'h0;
		cyc(6);
		check_word("overflows", 1, n_ovf);
		check_word("matches", 1 + (int'(t1) < ext), n_match);
		// Pwm threshold is zero until the first wrap, then the written value
		check_word("pwm matches", 1 + (int'(t2) < ext), n_match2);
		check_word("illegal mode events", 0, n_quiet);
		check_bit("compare out", m_count >= t1, chan_out[1]);
		check_bit("compare out n", m_count < t1, chan_out_n[1]);
		check_bit("pwm out", m_count < t2, chan_out[2]);
		check_bit("illegal mode out", 1'h0, chan_out[3]);
		// A new pwm value below the count stays buffered until the next wrap
		wr(2, 16'h0001);
		cyc(6);
		check_bit("pwm buffered", m_count < t2, chan_out[2]);
		// Threshold at the count boundary, with and without a dead gap
		foreach (dts[j]) begin
			dead_enable = 1'h1;
			dead_time = dts[j];
			wr(1, m_count + 16'h0001);
			cyc(12);
			check_bit("compare low", 1'h0, chan_out[1]);
			wr(1, m_count);
			gap = 0;
			repeat (16) begin
				@(negedge clock);
				gap += (chan_out[1] === 1'h0 && chan_out_n[1] === 1'h0);
			end
			check_word("dead gap", {24'h0, dts[j]}, gap);
			check_bit("compare high", 1'h1, chan_out[1]);
		end
		dead_enable = 1'h0;
		// Each channel in turn captures; a compare-mode neighbour ignores its pin
		for (int i = 0; i < 4; i++) begin
			mode_code = 8'h55 & ~(8'h03 << (2 * i));
			cyc(2);
			pin(i, 1'h1);
			pin((i + 1) % 4, 1'h0);
		end
		// External tick pin; the model is paused while the pin path settles
		track = 1'h0;
		tick_select = 1'h1;
		run = 1'h1;
		k = next_rand() % 5 + 2;
		repeat (k) begin
			tick_pin = 1'h1;
			cyc(3);
			tick_pin = 1'h0;
			cyc(3);
		end
		cyc(6);
		m_count = m_count + k[15:0];
		track = 1'h1;
		cyc(4);
		run = 1'h0;
		tick_select = 1'h0;
		cyc(2);
		give_verdict();
	end
endmodule : compare_capture_timer_tb_top
